// >>> bench/pcr_bank_properties.sv
// Purpose: Port-level assertions for the pad control bank
// Assumes: Zero-wait APB, one clock, async active-low reset
// Notes: Bound into pcr_bank at the foot of this file
module pcr_bank_properties (
    input wire clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire [15:0] drive_code_bank3_group_c,
    input wire [7:0] slew_select_bank0_group_a,
    input wire [15:0] drive_ma_pin_en_2ma,
    input wire [15:0] drive_ma_pin_en_4ma,
    input wire [15:0] drive_ma_pin_en_12ma
);
    wire [15:0] dr = drive_code_bank3_group_c;
    wire acc = psel & penable;
    wire wr_dr = acc & pwrite & (paddr == 12'h238);
    wire wr_s0 = acc & pwrite & (paddr == 12'h300) & (pwdata[31:16] == 16'hFFFF);
    // ====
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_gate;
        wr_dr |=> dr == (($past(dr) & ~$past(pwdata[31:16])) | ($past(pwdata[15:0]) & $past(pwdata[31:16])));
    endproperty
    a_gate: assert property (p_gate) else $error("masked write wrong");
    property p_hold; !wr_dr |=> $stable(dr); endproperty
    a_hold: assert property (p_hold) else $error("drive changed unwritten");
    property p_slew; wr_s0 |=> slew_select_bank0_group_a == $past(pwdata[7:0]); endproperty
    a_slew: assert property (p_slew) else $error("slew group a wrong");
    property p_upper; acc && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("gate half not zero");
    property p_rd; acc && !pwrite && paddr == 12'h238 |-> prdata == {16'h0000, dr}; endproperty
    a_rd: assert property (p_rd) else $error("drive read wrong");
    property p_dec;
        drive_ma_pin_en_2ma[7] == (dr[15:14] == 2'h0) && drive_ma_pin_en_12ma[0] == (dr[1:0] == 2'h3);
    endproperty
    a_dec: assert property (p_dec) else $error("drive decode wrong");
    property p_4ma; drive_ma_pin_en_4ma[3] == (dr[7:6] == 2'h1); endproperty
    a_4ma: assert property (p_4ma) else $error("pin 3 decode wrong");
    property p_rst; $rose(rst_b) |-> dr == 16'hAAAA && slew_select_bank0_group_a == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
    c_wr: cover property (wr_dr);
    c_rd: cover property (acc && !pwrite);
    c_err: cover property (acc && pslverr);
endmodule

bind pcr_bank pcr_bank_properties i_pcr_bank_properties (.clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pslverr, .drive_code_bank3_group_c, .slew_select_bank0_group_a,
    .drive_ma_pin_en_2ma, .drive_ma_pin_en_4ma, .drive_ma_pin_en_12ma);

// >>> bench/tb_pad_control_register_bank.sv
// Purpose: Self-checking bench for the pad control bank
// Assumes: APB master waits for pready, 250 MHz clock
// Notes: Table rows first, then partial gates, decode, errors, reset
module tb_pad_control_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [11:0] a; logic [15:0] r;} pcr_row_t;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    wire pready, pslverr;
    wire [31:0] prdata;
    wire [15:0] drive_code_bank3_group_c, drive_ma_pin_en_2ma, drive_ma_pin_en_4ma, drive_ma_pin_en_12ma;
    wire [7:0] grp [0:23];
    int mismatches = 0, n_compared = 0, k;
    pcr_row_t rows[13] = '{'{12'h238, 16'hAAAA}, '{12'h300, 16'h0}, '{12'h304, 16'h0}, '{12'h308, 16'h0},
        '{12'h30C, 16'h0}, '{12'h310, 16'h0}, '{12'h314, 16'h0}, '{12'h318, 16'h0}, '{12'h31C, 16'h0},
        '{12'h380, 16'h0}, '{12'h384, 16'h0}, '{12'h388, 16'h0}, '{12'h38C, 16'h0}};
    pcr_bank i_pcr_bank (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .drive_code_bank3_group_c, .drive_ma_pin_en_2ma, .drive_ma_pin_en_4ma, .drive_ma_pin_en_12ma,
        .slew_select_bank0_group_a(grp[0]), .slew_select_bank0_group_b(grp[1]), .slew_select_bank0_group_c(grp[2]),
        .slew_select_bank0_group_d(grp[3]), .slew_select_bank1_group_a(grp[4]), .slew_select_bank1_group_b(grp[5]),
        .slew_select_bank1_group_c(grp[6]), .slew_select_bank1_group_d(grp[7]), .slew_select_bank2_group_a(grp[8]),
        .slew_select_bank2_group_b(grp[9]), .slew_select_bank2_group_c(grp[10]), .slew_select_bank2_group_d(grp[11]),
        .slew_select_bank3_group_a(grp[12]), .slew_select_bank3_group_b(grp[13]), .slew_select_bank3_group_c(grp[14]),
        .slew_select_bank3_group_d(grp[15]), .hysteresis_bank0_group_a(grp[16]), .hysteresis_bank0_group_b(grp[17]),
        .hysteresis_bank0_group_c(grp[18]), .hysteresis_bank0_group_d(grp[19]), .hysteresis_bank1_group_a(grp[20]),
        .hysteresis_bank1_group_b(grp[21]), .hysteresis_bank1_group_c(grp[22]), .hysteresis_bank1_group_d(grp[23]));
    initial forever #2 clk = ~clk;
    // ====
    // Tasks
    task automatic chk(input logic [31:0] s, e, input string n);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            mismatches++;
            give_verdict();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // ====
    // Sequence
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, {16'h0, rows[i].r}, "reset value");
            apb(1'b1, rows[i].a, 32'hFFFF5A30 + i);
            apb(1'b1, rows[i].a, 32'h0000FFFF);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rd, 32'h5A30 + i, "masked write");
            chk({31'h0, err}, 32'h0, "mapped error");
            if (i == 0)
                chk({16'h0, drive_code_bank3_group_c}, 32'h5A30, "drive pins");
            else
                chk({16'h0, grp[2*i-1], grp[2*i-2]}, 32'h5A30 + i, "group pins");
        end
        $display("table done");
        apb(1'b1, 12'h238, 32'h0F0FFFFF);
        @(negedge clk);
        chk({16'h0, drive_code_bank3_group_c}, 32'h5F3F, "partial gate");
        apb(1'b1, 12'h238, 32'hFFFFE4E4);
        @(negedge clk);
        chk({drive_ma_pin_en_4ma, drive_ma_pin_en_2ma}, 32'h00220011, "decode 4 2");
        chk({16'h0, drive_ma_pin_en_12ma}, 32'h0088, "decode 12");
        apb(1'b1, 12'h300, 32'hFFFFA55A);
        apb(1'b1, 12'h38C, 32'hFFFFC33C);
        @(negedge clk);
        chk({16'h0, grp[1], grp[0]}, 32'hA55A, "slew");
        chk({16'h0, grp[23], grp[22]}, 32'hC33C, "hyst");
        $display("fields done");
        apb(1'b1, 12'h23C, 32'hFFFF0000);
        apb(1'b0, 12'h23C, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk({16'h0, drive_code_bank3_group_c}, 32'hE4E4, "unmapped write");
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({drive_code_bank3_group_c, 8'h0, grp[0]}, 32'hAAAA0000, "rerun reset");
        $display("errors and reset done");
        give_verdict();
    end
endmodule

// >>> common/pcr_defines.vh
// Purpose: Offsets, reset values and field positions of the pad control bank
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

`define PCR_ADDR_W 12
`define PCR_OFF_DRIVE_B3C 12'h238
`define PCR_OFF_SLEW_B0L 12'h300
`define PCR_OFF_SLEW_B0H 12'h304
`define PCR_OFF_SLEW_B1L 12'h308
`define PCR_OFF_SLEW_B1H 12'h30C
`define PCR_OFF_SLEW_B2L 12'h310
`define PCR_OFF_SLEW_B2H 12'h314
`define PCR_OFF_SLEW_B3L 12'h318
`define PCR_OFF_SLEW_B3H 12'h31C
`define PCR_OFF_HYST_B0L 12'h380
`define PCR_OFF_HYST_B0H 12'h384
`define PCR_OFF_HYST_B1L 12'h388
`define PCR_OFF_HYST_B1H 12'h38C

`define PCR_RST_DRIVE 16'hAAAA
`define PCR_RST_SLEW 16'h0000
`define PCR_RST_HYST 16'h0000

`define PCR_CTRL_MSB 15
`define PCR_GATE_LSB 16
`define PCR_GROUP_W 8

`define PCR_DRIVE_2MA 2'h0
`define PCR_DRIVE_4MA 2'h1
`define PCR_DRIVE_CODE10 2'h2
`define PCR_DRIVE_12MA 2'h3

`endif

// >>> rtl/pcr_bank.v
// Purpose: APB register bank for pad drive, slew and hysteresis controls
// Assumes: APB3 slave, zero wait states, synchronous inputs
// Notes: Unmapped addresses read zero, ignore writes and raise pslverr
//
// Added by the designer: the APB register port.
`include "pcr_defines.vh"

// How it works
// - A write changes control bit n only if bit n+16 of the word is one.
// - With gate bit n+16 zero, control bit n keeps its old value.
// - Upper sixteen gate bits are write-only strobes, never stored, read zero.
// - Drive register holds eight pins, two bits each.
// - Drive code 00 is 2mA, 01 is 4mA, 11 is 12mA.
// - Drive half-word resets to 0xAAAA.
// - One slew bit per pin: zero slow, one fast.
// - Slew register bits 15:8 second group, bits 7:0 first group.
// - One hysteresis bit per pin: zero off, one Schmitt input.
// - Hysteresis register bits 15:8 second group, bits 7:0 first group.
// - Slew and hysteresis fields reset to zero.
module pcr_bank (
    input wire clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PCR_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    output wire [15:0] drive_code_bank3_group_c,
    output wire [7:0] slew_select_bank0_group_a,
    output wire [7:0] slew_select_bank0_group_b,
    output wire [7:0] slew_select_bank0_group_c,
    output wire [7:0] slew_select_bank0_group_d,
    output wire [7:0] slew_select_bank1_group_a,
    output wire [7:0] slew_select_bank1_group_b,
    output wire [7:0] slew_select_bank1_group_c,
    output wire [7:0] slew_select_bank1_group_d,
    output wire [7:0] slew_select_bank2_group_a,
    output wire [7:0] slew_select_bank2_group_b,
    output wire [7:0] slew_select_bank2_group_c,
    output wire [7:0] slew_select_bank2_group_d,
    output wire [7:0] slew_select_bank3_group_a,
    output wire [7:0] slew_select_bank3_group_b,
    output wire [7:0] slew_select_bank3_group_c,
    output wire [7:0] slew_select_bank3_group_d,
    output wire [7:0] hysteresis_bank0_group_a,
    output wire [7:0] hysteresis_bank0_group_b,
    output wire [7:0] hysteresis_bank0_group_c,
    output wire [7:0] hysteresis_bank0_group_d,
    output wire [7:0] hysteresis_bank1_group_a,
    output wire [7:0] hysteresis_bank1_group_b,
    output wire [7:0] hysteresis_bank1_group_c,
    output wire [7:0] hysteresis_bank1_group_d,
    output wire [15:0] drive_ma_pin_en_2ma,
    output wire [15:0] drive_ma_pin_en_4ma,
    output wire [15:0] drive_ma_pin_en_12ma
);

    localparam integer NREG = 13;
    localparam integer IDX_DRIVE = 0;

    // ===========================================
    // Address decode
    // ===========================================
    reg [NREG-1:0] hit;
    always @* begin
        hit = {NREG{1'b0}};
        case (paddr)
            `PCR_OFF_DRIVE_B3C: hit[0] = 1'b1;
            `PCR_OFF_SLEW_B0L: hit[1] = 1'b1;
            `PCR_OFF_SLEW_B0H: hit[2] = 1'b1;
            `PCR_OFF_SLEW_B1L: hit[3] = 1'b1;
            `PCR_OFF_SLEW_B1H: hit[4] = 1'b1;
            `PCR_OFF_SLEW_B2L: hit[5] = 1'b1;
            `PCR_OFF_SLEW_B2H: hit[6] = 1'b1;
            `PCR_OFF_SLEW_B3L: hit[7] = 1'b1;
            `PCR_OFF_SLEW_B3H: hit[8] = 1'b1;
            `PCR_OFF_HYST_B0L: hit[9] = 1'b1;
            `PCR_OFF_HYST_B0H: hit[10] = 1'b1;
            `PCR_OFF_HYST_B1L: hit[11] = 1'b1;
            `PCR_OFF_HYST_B1H: hit[12] = 1'b1;
            default: hit = {NREG{1'b0}};
        endcase
    end

    wire access = psel && penable;
    wire mapped = |hit;
    // Zero wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ===========================================
    // Register instances
    // ===========================================
    wire [15:0] val [0:NREG-1];

    genvar r;
    generate
        for (r = 0; r < NREG; r = r + 1) begin : g_reg
            // Drive resets to AAAA slew and hysteresis reset clear
            pcr_masked_reg #(
                .RESET_VAL((r == IDX_DRIVE) ? `PCR_RST_DRIVE : ((r < 9) ? `PCR_RST_SLEW : `PCR_RST_HYST))
            ) u_reg (
                .clk(clk),
                .rst_b(rst_b),
                .wr_en(access && pwrite && hit[r]),
                .wr_data(pwdata),
                .value(val[r])
            );
        end
    endgenerate

    // ===========================================
    // Read path
    // ===========================================
    reg [15:0] rd_ctrl;
    integer k;
    always @* begin
        rd_ctrl = 16'h0000;
        for (k = 0; k < NREG; k = k + 1) begin
            if (hit[k]) begin
                rd_ctrl = rd_ctrl | val[k];
            end
        end
    end
    // Captured in the setup cycle so read data stands from a flop through the access cycle
    reg [31:0] prdata_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            // Gate half never stored, so it reads zero
            prdata_q <= {16'h0000, rd_ctrl};
        end else if (!access) begin
            prdata_q <= 32'h0000_0000;
        end
    end
    assign prdata = prdata_q;

    // ===========================================
    // Pad outputs
    // ===========================================
    assign drive_code_bank3_group_c = val[0];

    // Low register feeds groups A/B, high register C/D
    assign slew_select_bank0_group_a = val[1][`PCR_GROUP_W-1:0];
    assign slew_select_bank0_group_b = val[1][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank0_group_c = val[2][`PCR_GROUP_W-1:0];
    assign slew_select_bank0_group_d = val[2][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank1_group_a = val[3][`PCR_GROUP_W-1:0];
    assign slew_select_bank1_group_b = val[3][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank1_group_c = val[4][`PCR_GROUP_W-1:0];
    assign slew_select_bank1_group_d = val[4][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank2_group_a = val[5][`PCR_GROUP_W-1:0];
    assign slew_select_bank2_group_b = val[5][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank2_group_c = val[6][`PCR_GROUP_W-1:0];
    assign slew_select_bank2_group_d = val[6][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank3_group_a = val[7][`PCR_GROUP_W-1:0];
    assign slew_select_bank3_group_b = val[7][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign slew_select_bank3_group_c = val[8][`PCR_GROUP_W-1:0];
    assign slew_select_bank3_group_d = val[8][`PCR_CTRL_MSB:`PCR_GROUP_W];

    // Schmitt enables, same group split
    assign hysteresis_bank0_group_a = val[9][`PCR_GROUP_W-1:0];
    assign hysteresis_bank0_group_b = val[9][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign hysteresis_bank0_group_c = val[10][`PCR_GROUP_W-1:0];
    assign hysteresis_bank0_group_d = val[10][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign hysteresis_bank1_group_a = val[11][`PCR_GROUP_W-1:0];
    assign hysteresis_bank1_group_b = val[11][`PCR_CTRL_MSB:`PCR_GROUP_W];
    assign hysteresis_bank1_group_c = val[12][`PCR_GROUP_W-1:0];
    assign hysteresis_bank1_group_d = val[12][`PCR_CTRL_MSB:`PCR_GROUP_W];

    // ===========================================
    // Drive code decode, pin n at bits 2n+1:2n
    // ===========================================
    // Code 10 is left undecoded: its strength is not reliably known
    genvar p;
    generate
        for (p = 0; p < 8; p = p + 1) begin : g_pin
            wire [1:0] code = val[0][2*p+1:2*p];
            assign drive_ma_pin_en_2ma[p] = (code == `PCR_DRIVE_2MA);
            assign drive_ma_pin_en_4ma[p] = (code == `PCR_DRIVE_4MA);
            assign drive_ma_pin_en_12ma[p] = (code == `PCR_DRIVE_12MA);
            assign drive_ma_pin_en_2ma[p+8] = 1'b0;
            assign drive_ma_pin_en_4ma[p+8] = 1'b0;
            assign drive_ma_pin_en_12ma[p+8] = 1'b0;
        end
    endgenerate

endmodule

// >>> rtl/pcr_masked_reg.v
// Purpose: One 16-bit control half-word with per-bit write gating
// Assumes: wr_en is a single-cycle write strobe from the bus slave
// Notes: Gating bits are never stored
`include "pcr_defines.vh"

module pcr_masked_reg #(
    parameter [15:0] RESET_VAL = 16'h0000
) (
    input wire clk,
    input wire rst_b,
    input wire wr_en,
    input wire [31:0] wr_data,
    output wire [15:0] value
);

    reg [15:0] ctrl_q;

    genvar n;
    generate
        for (n = 0; n < 16; n = n + 1) begin : g_bit
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ctrl_q[n] <= RESET_VAL[n];
                end else if (wr_en && wr_data[n + `PCR_GATE_LSB]) begin
                    ctrl_q[n] <= wr_data[n];
                end
                // Gate low: bit holds
            end
        end
    endgenerate

    assign value = ctrl_q;

endmodule
